//--- verilog/bccb_pkg.sv
// bccb_pkg: constants for the bit-clear and conditional-branch executor.
// assumes a 16-bit instruction word and a byte-addressed program counter.
package bccb_pkg;
   localparam int BCCB_PC_W = 21;
   localparam int BCCB_DADDR_W = 12;
   // opcode fields
   localparam logic [3:0] BCCB_OP_BIT_CLEAR = 4'h9;
   localparam logic [7:0] BCCB_OP_BRANCH_IF_NEGATIVE = 8'hE6;
   localparam logic [7:0] BCCB_OP_BRANCH_UNLESS_CARRY = 8'hE3;
   localparam int BCCB_BIT_IDX_POS = 9;
   localparam int BCCB_ACCESS_POS = 8;
   // access bank split: low addresses map to bank 0, high ones to bank F
   localparam logic [7:0] BCCB_ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] BCCB_INDEXED_MAX = 8'h5F;
   localparam logic [3:0] BCCB_ACCESS_HIGH_BANK = 4'hF;
   localparam logic [BCCB_PC_W-1:0] BCCB_PC_STEP = 21'h000002;
   localparam logic [BCCB_PC_W-1:0] BCCB_PC_RESET = 21'h000000;
   localparam int BCCB_Q_PHASES = 4;
   typedef enum logic [1:0] {BCCB_Q1, BCCB_Q2, BCCB_Q3, BCCB_Q4} bccb_q_e;
endpackage : bccb_pkg

//--- verilog/bccb_addr_resolve.sv
// bccb_addr_resolve: forms the full data address of a file operand.
// assumes the indexing base register is supplied by the core.
`timescale 1ns/1ps
module bccb_addr_resolve
   import bccb_pkg::*;
(
   input wire logic [7:0] i_file_addr,
   input wire logic i_access_sel,
   input wire logic [3:0] i_bank_select_register,
   input wire logic i_ext_set_en,
   input wire logic [BCCB_DADDR_W-1:0] i_index_base,
   output logic [BCCB_DADDR_W-1:0] o_data_addr
);
   always_comb begin
      if (i_access_sel) begin
         o_data_addr = {i_bank_select_register, i_file_addr}; // see RL3
      end else if (i_ext_set_en && (i_file_addr <= BCCB_INDEXED_MAX)) begin
         // indexed literal offset: base plus the literal
         o_data_addr = i_index_base + {4'h0, i_file_addr}; // see RL4
      end else if (i_file_addr < BCCB_ACCESS_SPLIT) begin
         o_data_addr = {4'h0, i_file_addr}; // see RL2
      end else begin
         o_data_addr = {BCCB_ACCESS_HIGH_BANK, i_file_addr}; // see RL2
      end
   end
endmodule : bccb_addr_resolve

//--- verilog/bccb_exec.sv
// bccb_exec: decodes and executes bit clear and two conditional branches.
// assumes one instruction is presented per four-phase instruction cycle,
// data memory read data is valid in Q3 for the address set in Q2.
// Contract
// RL1: bit clear forces the indexed bit of the file register to zero only.
// RL2: access-select zero resolves the file address in the access bank.
// RL3: access-select one uses the bank select register for the bank.
// RL4: extended set, access zero, address up to 95 uses indexed offset.
// RL5: branch unless carry, prefix E3, jumps only when carry is clear.
// RL6: taken branch target is PC plus two plus twice signed offset.
// RL7: a taken branch takes two cycles; the second is a no-operation.
// RL8: an untaken branch takes one cycle and continues two bytes on.
// RL9: branch if negative, prefix E6, jumps on negative; no flags change.
`timescale 1ns/1ps
module bccb_exec
   import bccb_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_instr,
   input wire logic i_instr_valid,
   input wire logic [3:0] i_bank_select_register,
   input wire logic i_ext_set_en,
   input wire logic [BCCB_DADDR_W-1:0] i_index_base,
   input wire logic i_flag_negative,
   input wire logic i_flag_carry,
   input wire logic [7:0] i_mem_rdata,
   output logic [BCCB_DADDR_W-1:0] o_mem_addr,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [7:0] o_mem_wdata,
   output logic [BCCB_PC_W-1:0] o_pc,
   output logic o_pc_load,
   output logic o_flush,
   output logic [1:0] o_q_phase
);
   bccb_q_e q;
   bccb_q_e next_q;
   logic [15:0] ir;
   logic ir_valid;
   logic nop_cycle;
   logic [BCCB_PC_W-1:0] pc;
   logic [BCCB_PC_W-1:0] next_pc;
   logic [BCCB_DADDR_W-1:0] next_addr;
   logic [7:0] clear_mask;
   logic live;
   logic is_clear;
   logic is_bn;
   logic is_bnc;
   logic take;
   logic [BCCB_PC_W-1:0] offset2;

   // the doubled offset needs at least one sign bit above the literal
   if (BCCB_PC_W < 10) begin : g_pc_w_check
      $error("program counter too narrow for a doubled branch offset");
   end
   // the address former joins a bank nibble to a file byte
   if (BCCB_DADDR_W != 12) begin : g_daddr_w_check
      $error("data address must be one bank nibble and one file byte");
   end
   // the phase enum carries exactly four states
   if (BCCB_Q_PHASES != 4) begin : g_q_check
      $error("the sequencer serves four phases only");
   end

   // a word counts only when flagged valid and not in a refill slot
   assign live = ir_valid && !nop_cycle;
   assign is_clear = live && (ir[15:12] == BCCB_OP_BIT_CLEAR);
   assign is_bn = live &&
      (ir[15:8] == BCCB_OP_BRANCH_IF_NEGATIVE);
   assign is_bnc = live &&
      (ir[15:8] == BCCB_OP_BRANCH_UNLESS_CARRY);
   // flags are only read: neither branch writes status
   assign take = (is_bn && i_flag_negative) // see RL9
      || (is_bnc && !i_flag_carry); // see RL5
   // sign-extend and double the offset
   assign offset2 = {{(BCCB_PC_W-9){ir[7]}}, ir[7:0], 1'b0}; // see RL6

   // one-hot mask of the bit to clear
   for (genvar b = 0; b < 8; b++) begin : g_clear_mask
      assign clear_mask[b] = (ir[BCCB_BIT_IDX_POS +: 3] == 3'(b)); // see RL1
   end

   bccb_addr_resolve u_addr (
      .i_file_addr(ir[7:0]),
      .i_access_sel(ir[BCCB_ACCESS_POS]),
      .i_bank_select_register(i_bank_select_register),
      .i_ext_set_en(i_ext_set_en),
      .i_index_base(i_index_base),
      .o_data_addr(next_addr)
   );

   // phase sequencer: one instruction cycle is four clocks
   always_comb begin
      case (q)
         BCCB_Q1: next_q = BCCB_Q2;
         BCCB_Q2: next_q = BCCB_Q3;
         BCCB_Q3: next_q = BCCB_Q4;
         BCCB_Q4: next_q = BCCB_Q1;
         default: next_q = BCCB_Q1;
      endcase
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         q <= BCCB_Q1;
      end else begin
         q <= next_q;
      end
   end

   // the phase output lets the fetch side align with the decode slot
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_q_phase <= 2'h0;
      end else begin
         o_q_phase <= 2'(next_q);
      end
   end

   // instruction latched at Q1 (decode)
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ir <= 16'h0000;
         ir_valid <= 1'b0;
      end else if (q == BCCB_Q1) begin
         ir <= i_instr;
         ir_valid <= i_instr_valid;
      end
   end

   // a taken branch turns the following cycle into a no-operation
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         nop_cycle <= 1'b0;
      end else if (q == BCCB_Q4) begin
         nop_cycle <= take; // see RL7
      end
   end

   // address holds after the access: cheaper than clearing it each cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_addr <= '0;
      end else if (q == BCCB_Q2 && is_clear) begin
         o_mem_addr <= next_addr; // see RL2
      end
   end

   // read strobe after Q2 so the data stands at the Q3 edge
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_rd <= 1'b0;
      end else begin
         o_mem_rd <= (q == BCCB_Q2) && is_clear;
      end
   end

   // only the selected bit drops, the rest pass through
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_wdata <= 8'h00;
      end else if (q == BCCB_Q3 && is_clear) begin
         o_mem_wdata <= i_mem_rdata & ~clear_mask; // see RL1
      end
   end

   // write strobe after Q3; the memory stores it at the Q4 edge
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_wr <= 1'b0;
      end else begin
         o_mem_wr <= (q == BCCB_Q3) && is_clear;
      end
   end

   // next sequential address, or the target when the branch is taken
   always_comb begin
      if (take) begin
         next_pc = pc + BCCB_PC_STEP + offset2; // see RL6
      end else begin
         next_pc = pc + BCCB_PC_STEP; // see RL8
      end
   end

   // program counter: advances every cycle, a taken branch reloads it
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pc <= BCCB_PC_RESET;
      end else if (q == BCCB_Q4) begin
         pc <= next_pc;
      end
   end

   // the core sees the same address that the executor keeps
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_pc <= BCCB_PC_RESET;
      end else if (q == BCCB_Q4) begin
         o_pc <= next_pc;
      end
   end

   // load and flush pulse together for one clock after the Q4 edge
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_pc_load <= 1'b0;
      end else begin
         o_pc_load <= (q == BCCB_Q4) && take; // see RL6
      end
   end

   // the fetch side drops the word it already holds
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_flush <= 1'b0;
      end else begin
         o_flush <= (q == BCCB_Q4) && take; // see RL7
      end
   end
endmodule : bccb_exec

//--- verification/bccb_exec_checker.sv
// bccb_exec_checker: port-level checks of the executor.
// assumes one instruction per four clocks and flags steady per cycle.
`timescale 1ns/1ps
module bccb_exec_checker
   import bccb_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic i_ext_set_en,
   input wire logic i_flag_carry,
   input wire logic i_flag_negative,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr,
   input wire logic o_pc_load,
   input wire logic o_flush,
   input wire logic [15:0] i_instr,
   input wire logic [3:0] i_bank_select_register,
   input wire logic [11:0] i_index_base,
   input wire logic [11:0] o_mem_addr,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [7:0] o_mem_wdata,
   input wire logic [20:0] o_pc,
   input wire logic [1:0] o_q_phase
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [15:0] ir;
   // operand kept until the write has been seen
   always_ff @(posedge i_core_clk) if (o_q_phase == 2'h0) ir <= i_instr;
   a_clear_bit: assert property (o_mem_wr |-> o_mem_wdata ==
      ($past(i_mem_rdata) & ~(8'h01 << ir[11:9]))) else $error("bad clear");
   a_addr_pick: assert property (o_mem_rd |-> o_mem_addr ==
      (!ir[8] && i_ext_set_en && ir[7:0] <= 8'h5F ? i_index_base + ir[7:0] :
      {ir[8] ? i_bank_select_register : ir[7:0] < 8'h60 ? 4'h0 : 4'hF,
      ir[7:0]})) else $error("bad address");
   // a word sampled while the flush pulse stands falls in the refill slot
   a_carry_jump: assert property (o_q_phase == 2'h0 &&
      i_instr_valid && !o_flush &&
      i_instr[15:8] == BCCB_OP_BRANCH_UNLESS_CARRY |-> ##4
      o_pc_load == !$past(i_flag_carry)) else $error("bad carry branch");
   a_neg_jump: assert property (o_q_phase == 2'h0 &&
      i_instr_valid && !o_flush &&
      i_instr[15:8] == BCCB_OP_BRANCH_IF_NEGATIVE |-> ##4
      o_pc_load == $past(i_flag_negative)) else $error("bad negative branch");
   a_jump_target: assert property (o_pc_load |-> o_pc == $past(o_pc) +
      21'h2 + {{12{ir[7]}}, ir[7:0], 1'b0})
      else $error("bad target");
   a_phase_step: assert property (!$past(i_rst) |->
      o_q_phase == $past(o_q_phase) + 2'h1) else $error("bad phase order");
   a_taken_nop: assert property (o_pc_load |=>
      (!o_pc_load && !o_mem_rd) [*4]) else $error("no idle cycle");
   a_flush_pair: assert property (o_flush == o_pc_load)
      else $error("flush without load");
   a_pc_step: assert property ($changed(o_pc) && !o_pc_load |->
      o_pc == $past(o_pc) + 21'h2) else $error("bad pc step");
   c_clear: cover property (o_mem_wr);
   c_taken: cover property (o_pc_load);
   c_indexed: cover property (o_mem_rd && i_ext_set_en && !ir[8]);
endmodule : bccb_exec_checker
bind bccb_exec bccb_exec_checker i_bccb_exec_checker (.*);

//--- verification/bccb_mem_model.sv
// bccb_mem_model: data memory behind the executor.
// assumes one-cycle strobes; bytes preset to address xor C7.
`timescale 1ns/1ps
module bccb_mem_model (
   input wire logic i_core_clk,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [11:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] last = 8'h00;
   logic rd_d = 1'b0;
   // toggles between reads so a sample two clocks late shows as wrong data
   assign o_rdata = i_rd || rd_d ? mem[i_addr] : ~last;
   initial for (int k = 0; k < 4096; k++) mem[k] = k[7:0] ^ 8'hC7;
   always @(posedge i_core_clk) begin
      rd_d <= i_rd;
      last <= o_rdata;
      if (i_wr) mem[i_addr] <= i_wdata;
   end
endmodule : bccb_mem_model

//--- verification/bccb_exec_tb_top.sv
// bccb_exec_tb_top: bit clears and branches through the executor.
// assumes the memory model preset pattern.
`timescale 1ns/1ps
module bccb_exec_tb_top;
   import bccb_pkg::*;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0;
   logic i_ext_set_en = 1'b0, i_flag_negative = 1'b0, i_flag_carry = 1'b0;
   logic [15:0] i_instr = 16'h0000;
   logic [3:0] i_bank_select_register = 4'hA;
   logic [11:0] i_index_base = 12'h200, o_mem_addr, a;
   logic [7:0] i_mem_rdata, o_mem_wdata, f;
   logic [20:0] o_pc, pa;
   logic o_mem_rd, o_mem_wr, o_pc_load, o_flush;
   logic [1:0] o_q_phase;
   int bad_count = 0, checked = 0;
   always #5 i_core_clk = ~i_core_clk;
   bccb_exec i_bccb_exec (.*);
   bccb_mem_model i_bccb_mem_model (.i_core_clk, .i_addr(o_mem_addr),
      .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_wdata(o_mem_wdata),
      .o_rdata(i_mem_rdata));
   task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic run(logic [15:0] w, logic e, logic [1:0] fl, int n);
      do @(negedge i_core_clk); while (o_q_phase !== 2'h3);
      @(posedge i_core_clk);
      i_instr <= w;
      i_ext_set_en <= e;
      {i_flag_negative, i_flag_carry} <= fl;
      repeat (n) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask : run
   task automatic t_clear;
      for (int i = 0; i < 16; i++) begin
         f = 8'h5C + i[7:0];
         a = i[0] ^ i[1] ? {4'hA, f} : i[1] && f <= 8'h5F ? 12'h200 + f :
            {f < 8'h60 ? 4'h0 : 4'hF, f};
         run({BCCB_OP_BIT_CLEAR, i[2:0], i[0] ^ i[1], f}, i[1], 2'h0, 5);
         chk("byte", (a[7:0] ^ 8'hC7) & ~(8'h01 << i[2:0]),
            i_bccb_mem_model.mem[a]);
      end
      $display("bit clear test done");
   endtask : t_clear
   task automatic t_branch;
      for (int j = 0; j < 16; j++) begin
         f = j[3] ? (j[2] ? 8'h80 : 8'h7F) : (j[2] ? 8'hFF : 8'h03);
         run({j[0] ? BCCB_OP_BRANCH_UNLESS_CARRY : BCCB_OP_BRANCH_IF_NEGATIVE,
            f}, 1'b0, j[2:1], 1);
         pa = o_pc;
         repeat (4) @(posedge i_core_clk);
         @(negedge i_core_clk);
         chk("pc", pa + 21'h2 + ((j[0] ? !j[1] : j[2]) ?
            {{12{f[7]}}, f, 1'b0} : 21'h0), o_pc);
      end
      $display("branch test done");
   endtask : t_branch
   // a word without its valid flag must leave the counter on its plain step
   task automatic t_idle;
      @(posedge i_core_clk);
      i_instr_valid <= 1'b0;
      run({BCCB_OP_BRANCH_UNLESS_CARRY, 8'h10}, 1'b0, 2'h0, 1);
      pa = o_pc;
      repeat (4) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk("idle pc", pa + 21'h2, o_pc);
      @(posedge i_core_clk);
      i_instr_valid <= 1'b1;
      $display("ignored word test done");
   endtask : t_idle
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      i_instr_valid <= 1'b1;
      t_clear;
      t_branch;
      t_idle;
      test_done;
   end
   initial begin
      #20000;
      bad_count++;
      test_done;
   end
endmodule : bccb_exec_tb_top
